// >>> src/pbss_pkg.sv
// Shared constants and carrier types for the pipelined burst synchronous memory
package pbss_pkg;
   // Geometry: wide variant 256K x 36, narrow variant 512K x 18
   localparam int PBSS_WIDE_WORDS = 262144;
   localparam int PBSS_WIDE_BITS = 36;
   localparam int PBSS_NARROW_WORDS = 524288;
   localparam int PBSS_NARROW_BITS = 18;
   localparam int PBSS_LANE_BITS = 9;
   localparam int PBSS_BURST_BITS = 2;
   localparam logic [1:0] PBSS_BURST_ZERO = 2'h0;
   localparam logic [1:0] PBSS_BURST_ONE = 2'h1;
   localparam logic PBSS_ORDER_LINEAR = 1'h1;

   // Control sample taken at each edge (active-low signals kept as on the pins)
   typedef struct packed {
      logic proc_addr_strobe_n;
      logic ctrl_addr_strobe_n;
      logic burst_advance_n;
      logic byte_write_qualifier_n;
      logic all_lanes_write_n;
      logic pipeline_select_n;
      logic depth_select_hi;
      logic depth_select_lo_n;
   } pbss_ctrl_type;
endpackage : pbss_pkg

// >>> src/pbss_sram.sv
// Pipelined burst synchronous static memory core
// Functional notes
// - The array holds 256K words of 36 bits or 512K words of 18 bits by parameter.
// - Every synchronous input is captured in input registers at the rising clock edge.
// - Address and chip enables are latched only on an edge where a strobe is low.
// - Later burst addresses come from a two-bit counter stepped only by the advance input.
// - The counter follows interleaved or linear order per the order select input.
// - A registered write completes into the array without further strobing.
// - Lane enables, qualified by the byte qualifier, choose which bytes are written.
// - All-lanes write low writes every lane regardless of lane enables.
// - Output enable and sleep gate the drivers without waiting for a clock edge.
// - Read data passes an output register, first word after two clocks then one each.
// - On deselect the data outputs stop driving after one clock.
`timescale 1ns/1ps
`default_nettype none
module pbss_sram
   import pbss_pkg::*;
#(
   parameter int DATA_W = PBSS_WIDE_BITS,
   parameter int DEPTH = PBSS_WIDE_WORDS,
   parameter int ADDR_W = $clog2(DEPTH),
   parameter int LANES = DATA_W / PBSS_LANE_BITS
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Synchronous bus inputs
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire pbss_pkg::pbss_ctrl_type ctrl,
   input wire logic [LANES-1:0] lane_write_n,
   input wire logic burst_order_linear,
   // Asynchronous inputs
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // Data pins as three signals
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic [DATA_W-1:0] dq_oe
);
   import pbss_pkg::*;

   logic [DATA_W-1:0] mem [DEPTH];

   // Input stage
   pbss_ctrl_type ctl_ff, nxt_ctl;
   logic [ADDR_W-1:0] ain_ff, nxt_ain;
   logic [DATA_W-1:0] din_ff, nxt_din;
   logic [LANES-1:0] lwn_ff, nxt_lwn;
   logic ord_ff, nxt_ord;
   // Burst state
   logic [ADDR_W-1:0] base_ff, nxt_base;
   logic [PBSS_BURST_BITS-1:0] cnt_ff, nxt_cnt;
   logic sel_ff, nxt_sel;
   // Output stage
   logic rvld_ff, nxt_rvld;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [DATA_W-1:0] dq_out_ff;
   logic drive_ff, nxt_drive;
   // Sleep pin as seen by clocked logic
   logic sleep_meta_ff, sleep_sync_ff;

   logic strobe, deselect, start, step, wr_now;
   logic [ADDR_W-1:0] cur_addr;
   logic [LANES-1:0] lane_en;

   // Burst offset for either order
   function automatic logic [PBSS_BURST_BITS-1:0] burst_off(
      input logic [PBSS_BURST_BITS-1:0] start_off,
      input logic [PBSS_BURST_BITS-1:0] count,
      input logic linear);
      burst_off = linear ? start_off + count : start_off ^ count;
   endfunction

   always_comb
   begin
      nxt_ctl = ctrl;
      nxt_ain = addr;
      nxt_din = wdata;
      nxt_lwn = lane_write_n;
      nxt_ord = burst_order_linear;
   end

   always_comb
   begin
      strobe = !ctl_ff.proc_addr_strobe_n || !ctl_ff.ctrl_addr_strobe_n;
      deselect = ctl_ff.pipeline_select_n || !ctl_ff.depth_select_hi
         || ctl_ff.depth_select_lo_n;
      start = strobe && !deselect;
      step = !strobe && sel_ff && !ctl_ff.burst_advance_n;
      nxt_base = base_ff;
      nxt_cnt = cnt_ff;
      nxt_sel = sel_ff;
      if (strobe)
      begin
         nxt_base = ain_ff;
         nxt_cnt = PBSS_BURST_ZERO;
         nxt_sel = !deselect;
      end
      else if (step)
         nxt_cnt = cnt_ff + PBSS_BURST_ONE;
      cur_addr = strobe ? ain_ff : base_ff;
      if (!strobe)
         cur_addr[PBSS_BURST_BITS-1:0] =
            burst_off(base_ff[PBSS_BURST_BITS-1:0], nxt_cnt, ord_ff);
      // Write controls ignored on a processor-strobe edge
      for (int i = 0; i < LANES; i++)
         lane_en[i] = !ctl_ff.all_lanes_write_n
            || (!ctl_ff.byte_write_qualifier_n && !lwn_ff[i]);
      wr_now = (start && ctl_ff.proc_addr_strobe_n || step) && (|lane_en);
      nxt_rvld = (start || (!strobe && sel_ff)) && !wr_now;
      nxt_rdata = mem[cur_addr];
      nxt_drive = rvld_ff && sel_ff && !sleep_sync_ff;
      // A deselect also drops the word already in the output stage
      if (strobe && deselect)
         nxt_drive = 1'b0;
   end

   // Self-timed write into the array
   // Sleep blocks writes two clocks after the pin rises
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < LANES; i++)
         if (wr_now && lane_en[i] && !sleep_sync_ff)
            mem[cur_addr][i*PBSS_LANE_BITS +: PBSS_LANE_BITS] <=
               din_ff[i*PBSS_LANE_BITS +: PBSS_LANE_BITS];
   end

   // Two stages so a sleep edge near the clock cannot split one decision
   always_ff @(posedge clk_sys)
   begin
      sleep_meta_ff <= sleep_request;
      sleep_sync_ff <= sleep_meta_ff;
   end

   always_ff @(posedge clk_sys)
   begin
      ain_ff <= nxt_ain;
      din_ff <= nxt_din;
      lwn_ff <= nxt_lwn;
      rdata_ff <= nxt_rdata;
      if (!rstn)
      begin
         ctl_ff <= '1;
         ord_ff <= 1'b0;
         base_ff <= '0;
         cnt_ff <= PBSS_BURST_ZERO;
         sel_ff <= 1'b0;
         rvld_ff <= 1'b0;
         drive_ff <= 1'b0;
         dq_out_ff <= '0;
      end
      else
      begin
         ctl_ff <= nxt_ctl;
         ord_ff <= nxt_ord;
         base_ff <= nxt_base;
         cnt_ff <= nxt_cnt;
         sel_ff <= nxt_sel;
         rvld_ff <= nxt_rvld;
         drive_ff <= nxt_drive;
         dq_out_ff <= rdata_ff;
      end
   end

   // Output enable and sleep gate the drivers with no clock involved
   // Raw sleep pin here; clocked paths use the synchronised copy
   assign dq_out = dq_out_ff;
   assign dq_oe = {DATA_W{drive_ff && !output_enable_n && !sleep_request}};

   // Deselect wins over the word still in the output stage
   a_deselect_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
      (strobe && deselect) |=> !drive_ff)
      else $error("outputs still driven after deselect");

   a_desel_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      (strobe && deselect) |=> (!drive_ff) [*2])
      else $error("outputs came back right after deselect");

   // A read not cut by a deselect in the next cycle nor by sleep is driven two clocks after its start
   a_read_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && !wr_now && !sleep_sync_ff) ##1 (!(strobe && deselect) && !sleep_sync_ff)
      |=> drive_ff)
      else $error("read data not driven on time");

   a_no_access_desel: assert property (@(posedge clk_sys) disable iff (!rstn)
      (strobe && deselect) |-> !wr_now && !nxt_rvld)
      else $error("access started while deselected");

   a_hold_no_adv: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!strobe && ctl_ff.burst_advance_n) |=> $stable(cnt_ff))
      else $error("burst counter moved without advance");

   a_burst_step: assert property (@(posedge clk_sys) disable iff (!rstn)
      step |=> cnt_ff == $past(cnt_ff) + PBSS_BURST_ONE)
      else $error("burst counter missed an advance");

   a_global_lanes: assert property (@(posedge clk_sys) disable iff (!rstn)
      !ctl_ff.all_lanes_write_n |-> &lane_en)
      else $error("global write missed a lane");

   a_strobe_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
      strobe |=> base_ff == $past(ain_ff) && cnt_ff == PBSS_BURST_ZERO)
      else $error("strobed address not latched");

   a_base_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
      !strobe |=> $stable(base_ff))
      else $error("burst base moved without a strobe");

   a_input_reg: assert property (@(posedge clk_sys) disable iff (!rstn)
      1'b1 |=> ctl_ff == $past(ctrl))
      else $error("control input not registered");

   a_async_oe: assert property (@(posedge clk_sys) disable iff (!rstn)
      output_enable_n |-> dq_oe == '0)
      else $error("drivers on with output enable high");

   a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
      sleep_request |-> dq_oe == '0)
      else $error("drivers on while asleep");
endmodule // pbss_sram
`default_nettype wire

// >>> testbench/pbss_master.sv
// Bus master model for the burst memory
`timescale 1ns/1ps
`default_nettype none
module pbss_master (
   // Clock
   input wire logic clk_sys,
   // Memory bus
   output logic [5:0] addr,
   output logic [35:0] wdata,
   output var pbss_pkg::pbss_ctrl_type ctrl,
   output logic [3:0] lane_write_n,
   output logic burst_order_linear
);
   import pbss_pkg::*;
   logic [35:0] shadow [64];
   logic [35:0] exp_q [$];
   task automatic drive(input logic [7:0] c, logic [5:0] a, logic [35:0] d, logic [3:0] ln);
      @(posedge clk_sys);
      #1;
      ctrl = pbss_ctrl_type'(c);
      addr = a;
      wdata = d;
      lane_write_n = ln;
   endtask
   // Unused lines carry noise; idle is a deselect so outputs let go
   task automatic noise(input logic [7:0] c, int n);
      repeat (n) drive(c, 6'($urandom()), 36'($urandom()), 4'($urandom()));
   endtask
   // m: 0 controller write, 1 processor strobe, 2 deselected, 3 blocked by sleep
   task automatic write(input logic [5:0] a, logic [35:0] d, logic [3:0] ln, logic g, int m);
      drive({m == 1 ? 2'b01 : 2'b10, 2'b10, g, m == 2 ? 3'b110 : 3'b010}, a, d, ln);
      for (int i = 0; i < 4; i++)
         if (m == 0 && (!g || !ln[i]))
            shadow[a][9*i+:9] = d[9*i+:9];
      noise(8'hbe, 8);
   endtask
   task automatic read(input logic [5:0] a, logic lin, logic s, int note);
      burst_order_linear = lin;
      drive({s, ~s, 6'b111010}, a, 36'($urandom()), 4'($urandom()));
      for (int k = 0; k < 4 * note; k++)
         exp_q.push_back(shadow[{a[5:2], lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k)}]);
      noise(8'hda, 3);
      // Hold one beat so the last word leaves before the deselect
      noise(8'hfa, 1);
      noise(8'hbe, 8);
   endtask
   initial
      {ctrl, addr, wdata, lane_write_n, burst_order_linear} = {8'hfa, 47'h0};
endmodule // pbss_master
`default_nettype wire

// >>> testbench/pbss_sram_bench.sv
// Bench for the burst memory
`timescale 1ns/1ps
`default_nettype none
module pbss_sram_bench;
   import pbss_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, output_enable_n = 1'b0, sleep_request = 1'b0;
   logic burst_order_linear;
   logic [5:0] addr;
   logic [3:0] lane_write_n;
   logic [35:0] wdata, dq_out, dq_oe;
   pbss_ctrl_type ctrl;
   int n_errors = 0, compares = 0;
   pbss_master m (.clk_sys(clk_sys), .addr(addr), .wdata(wdata), .ctrl(ctrl),
      .lane_write_n(lane_write_n), .burst_order_linear(burst_order_linear));
   pbss_sram #(.DEPTH(64)) dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
      .wdata(wdata), .ctrl(ctrl), .lane_write_n(lane_write_n),
      .burst_order_linear(burst_order_linear), .output_enable_n(output_enable_n),
      .sleep_request(sleep_request), .dq_in(36'h0), .dq_out(dq_out), .dq_oe(dq_oe));
   task automatic check(input string w, logic [35:0] e, logic [35:0] g);
      compares++;
      n_errors += int'(g !== e);
      if (g !== e)
         $display("wrong value %s expected %h seen %h", w, e, g);
   endtask
   task automatic end_sim();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
      forever #5 clk_sys = ~clk_sys;
   // Sampled mid-cycle, where the outputs have settled
   always @(negedge clk_sys)
      if (dq_oe[0] === 1'b1 && m.exp_q.size() > 0)
         check("read word", m.exp_q.pop_front(), dq_out);
   initial
   begin
      void'($urandom(32'h2ab2a7ac));
      repeat (4) @(posedge clk_sys);
      #1 rstn = 1'b1;
      for (int i = 0; i < 16; i++)
         m.write(6'(i), 36'({$urandom(), $urandom()}), 4'h0, 1'b1, 0);
      for (int i = 0; i < 5; i++)
         m.write(6'(4 + i), 36'($urandom()), 4'(20'hfce >> 4 * i), i != 2, i / 3 * (i - 2));
      // Write while asleep must leave the old word in place
      sleep_request = 1'b1;
      m.write(6'h9, 36'($urandom()), 4'h0, 1'b1, 3);
      sleep_request = 1'b0;
      for (int i = 0; i < 16; i++)
         m.read(6'(4 + i % 8), i[3], i[1] ^ i[3], 1);
      fork
         m.read(6'h8, 1'b0, 1'b1, 0);
         begin
            repeat (5) @(posedge clk_sys);
            #1 check("oe on", 36'hfffffffff, dq_oe);
            output_enable_n = 1'b1;
            #1 check("oe off", 36'h0, dq_oe);
            @(posedge clk_sys);
            #1 output_enable_n = 1'b0;
            sleep_request = 1'b1;
            #1 check("sleep off", 36'h0, dq_oe);
            @(posedge clk_sys);
            #1 sleep_request = 1'b0;
         end
      join
      check("words left", 36'h0, 36'(m.exp_q.size()));
      check("released", 36'h0, dq_oe);
      end_sim();
   end
endmodule // pbss_sram_bench
`default_nettype wire
